// File: wd_pkg.sv
package wd_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL  = 8'h31;
    localparam logic [7:0] IDX_CAUSE = 8'h3b;
    localparam logic [7:0] IDX_KEY   = 8'h3c;
    localparam logic [7:0] IDX_KICK  = 8'h3d;
    localparam int unsigned ADDR_W   = 8;

    // control/status field positions
    localparam int unsigned BIT_FLAG  = 7;
    localparam int unsigned BIT_IE    = 6;
    localparam int unsigned BIT_TS3   = 5;
    localparam int unsigned BIT_WDE   = 3;
    localparam int unsigned BIT_CAUSE = 3;
    localparam int unsigned BIT_KICK  = 0;

    // reset value, timeout select limit and protection key
    localparam logic [3:0] TSEL_RESET = 4'h0;
    localparam logic [3:0] TSEL_MAX   = 4'h9;
    localparam logic [7:0] KEY_VALUE  = 8'hd8;

    // one instruction per clock, so the key window is four clocks
    localparam int unsigned INSTR_PER_CLK     = 1;
    localparam int unsigned KEY_WINDOW_INSTR  = 4;
    localparam logic [2:0]  KEY_WINDOW_CYCLES =
        3'(KEY_WINDOW_INSTR * INSTR_PER_CLK);

    // oscillator cycle counts
    localparam int unsigned BASE_CYCLES = 2048;
    localparam int unsigned CNT_W       = 21;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wd_pkg

// File: wd_tick_counter.sv
// oscillator-domain tick counting, sampled on the system clock
module wd_tick_counter
    import wd_pkg::*;
#(
    parameter int unsigned BASE = BASE_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // oscillator pin and control
    input  wire logic       osc_128k,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [3:0] tsel,
    // expiry
    output logic            timeout
);
    logic             osc_s1;
    logic             osc_s2;
    logic             osc_d;
    logic [CNT_W-1:0] count;

    // rising oscillator edge, read only after the second stage
    wire              tick = osc_s2 && !osc_d;
    wire [CNT_W-1:0]  last = CNT_W'((BASE << tsel) - 1);
    wire              hit  = tick && (count >= last);

    // two-stage synchroniser for the free-running oscillator
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_d  <= 1'b0;
        end else begin
            osc_s1 <= osc_128k;
            osc_s2 <= osc_s1;
            osc_d  <= osc_s2;
        end
    end

    // >= rather than == so a shortened timeout mid-count still expires
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count   <= '0;
            timeout <= 1'b0;
        end else begin
            timeout <= run && !clear && hit;
            if (clear || !run || hit) begin
                count <= '0;
            end else if (tick) begin
                count <= count + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_stop_clears;
        (!run || clear) |=> (count == '0 && !timeout);
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("counter not cleared while stopped or kicked");

    property p_expiry_at_limit;
        timeout |-> $past(count >= last) && $past(tick);
    endproperty
    a_expiry_at_limit: assert property (p_expiry_at_limit)
        else $error("timeout without reaching selected count");
endmodule : wd_tick_counter

// File: watchdog_timer_config.sv
// watchdog control block with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite slave port.
module watchdog_timer_config
    import wd_pkg::*;
#(
    parameter int unsigned BASE = BASE_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // fuse strap, high when programmed (safety level 2)
    input  wire logic              safety_level_fuse,
    // watchdog oscillator pin
    input  wire logic              osc_128k,
    // interrupt vector execution from the core
    input  wire logic              irq_ack,
    // watchdog outputs
    output logic                   wd_irq_request,
    output logic                   wd_reset_pulse,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    // fuse synchroniser
    logic       fuse_s1;
    logic       fuse_prog;
    // control/status state
    logic       wd_irq_flag;
    logic       wd_irq_enable;
    logic       wd_reset_enable;
    logic [3:0] timeout_select;
    logic       wd_reset_cause_flag;
    logic [2:0] key_window;
    logic       timeout;

    // the fuse is a strap pin; it passes two flops before use
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fuse_s1   <= 1'b0;
            fuse_prog <= 1'b0;
        end else begin
            fuse_s1   <= safety_level_fuse;
            fuse_prog <= fuse_s1;
        end
    end

    // ---- write channel: address and data are taken in one edge
    wire       wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire [5:0] wr_idx = s_axi_awaddr[7:2];
    wire       lane0  = s_axi_wstrb[0];
    wire [7:0] wbyte  = s_axi_wdata[7:0];
    wire       aw_ctrl  = (wr_idx == IDX_CTRL[5:0]);
    wire       aw_cause = (wr_idx == IDX_CAUSE[5:0]);
    wire       aw_key   = (wr_idx == IDX_KEY[5:0]);
    wire       aw_kick  = (wr_idx == IDX_KICK[5:0]);
    wire       aw_hit   = aw_ctrl || aw_cause || aw_key || aw_kick;
    wire       wr_ctrl  = wr_go && lane0 && aw_ctrl;
    wire       wr_cause = wr_go && lane0 && aw_cause;
    wire       wr_key   = wr_go && lane0 && aw_key;
    wire       kick     = wr_go && lane0 && aw_kick && wbyte[BIT_KICK];

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;

    // response follows the taking edge by one cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---- mode decode
    wire wde_eff  = fuse_prog || wd_reset_enable;
    wire irq_mode = !fuse_prog && wd_irq_enable;
    wire running  = wde_eff || wd_irq_enable;
    wire key_open = (key_window != 3'h0);
    wire pend     = wd_irq_flag && !irq_ack;

    // combined mode resets only when the earlier interrupt still waits
    wire to_irq = timeout && irq_mode && !(wde_eff && pend);
    wire to_rst = timeout && wde_eff
                  && (!irq_mode || pend);

    // ---- protected field decode for a control write
    wire [3:0] w_tsel   = {wbyte[BIT_TS3], wbyte[2:0]};
    wire       tsel_ok  = (w_tsel <= TSEL_MAX);
    // level 2 needs the key for the timeout; level 1 does not
    wire       tsel_may = tsel_ok && (!fuse_prog || key_open);
    // clearing reset enable needs the key and a clear cause flag
    wire       wde_drop = key_open && !wd_reset_cause_flag;
    wire       next_wde = wbyte[BIT_WDE]
                          || (wd_reset_enable && !wde_drop);

    // key window: four clocks after the key, closed by any control write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            key_window <= 3'h0;
        end else if (wr_key) begin
            key_window <= (wbyte == KEY_VALUE) ? KEY_WINDOW_CYCLES
                                               : 3'h0;
        end else if (wr_ctrl || !key_open) begin
            key_window <= 3'h0;
        end else begin
            key_window <= key_window - 3'h1;
        end
    end

    // reset enable and timeout select; a watchdog reset re-arms
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_reset_enable <= 1'b0;
            timeout_select  <= TSEL_RESET;
        end else if (wd_reset_pulse) begin
            wd_reset_enable <= 1'b1;
            timeout_select  <= TSEL_RESET;
        end else if (wr_ctrl) begin
            // under level 2 the written enable value is irrelevant
            wd_reset_enable <= fuse_prog ? wd_reset_enable : next_wde;
            if (tsel_may) begin
                timeout_select <= w_tsel;
            end
        end
    end

    // interrupt enable: the vector drops it in combined mode
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_irq_enable <= 1'b0;
        end else if (wd_reset_pulse) begin
            wd_irq_enable <= 1'b0;
        end else if (wr_ctrl) begin
            wd_irq_enable <= wbyte[BIT_IE];
        end else if (irq_ack && wd_irq_flag && wde_eff) begin
            wd_irq_enable <= 1'b0;
        end
    end

    // interrupt flag: a time-out in the clearing cycle still sets it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_irq_flag <= 1'b0;
        end else if (to_irq) begin
            wd_irq_flag <= 1'b1;
        end else if (wd_reset_pulse) begin
            wd_irq_flag <= 1'b0;
        end else if (irq_ack || (wr_ctrl && wbyte[BIT_FLAG])) begin
            wd_irq_flag <= 1'b0;
        end
    end

    // cause flag: only a power-on reset or a written zero clears it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_reset_cause_flag <= 1'b0;
        end else if (wd_reset_pulse) begin
            wd_reset_cause_flag <= 1'b1;
        end else if (wr_cause && !wbyte[BIT_CAUSE]) begin
            wd_reset_cause_flag <= 1'b0;
        end
    end

    // one clock wide reset pulse per expiry that resets (not per interrupt expiry)
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_reset_pulse <= 1'b0;
        end else begin
            wd_reset_pulse <= to_rst;
        end
    end

    // request is a level, so it may follow the two flops directly
    assign wd_irq_request = wd_irq_flag && wd_irq_enable;

    // counter cleared by kick, by stop and by its own reset pulse
    wd_tick_counter #(
        .BASE     (BASE)
    ) u_counter (
        .clk      (clk),
        .reset    (reset),
        .osc_128k (osc_128k),
        .run      (running),
        .clear    (kick || wd_reset_pulse),
        .tsel     (timeout_select),
        .timeout  (timeout)
    );

    // ---- read channel
    wire [5:0] rd_idx   = s_axi_araddr[7:2];
    wire       ar_ctrl  = (rd_idx == IDX_CTRL[5:0]);
    wire       ar_cause = (rd_idx == IDX_CAUSE[5:0]);
    wire       ar_zero  = (rd_idx == IDX_KEY[5:0])
                          || (rd_idx == IDX_KICK[5:0]);
    wire       ar_hit   = ar_ctrl || ar_cause || ar_zero;
    wire       ar_go    = s_axi_arvalid && !s_axi_rvalid;
    // bit four is reserved and always zero
    wire [7:0] ctrl_read  = {wd_irq_flag, wd_irq_enable,
                             timeout_select[3], 1'b0, wde_eff,
                             timeout_select[2:0]};
    wire [7:0] cause_read = {4'h0, wd_reset_cause_flag, 3'h0};
    wire [7:0] rd_byte    = ar_ctrl  ? ctrl_read
                          : ar_cause ? cause_read
                          : 8'h00;

    assign s_axi_arready = ar_go;

    // data is captured at the address edge and held until taken
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= ar_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_level2_enable_one;
        fuse_prog |-> ctrl_read[BIT_WDE] && running;
    endproperty
    a_level2_enable_one: assert property (p_level2_enable_one)
        else $error("level 2 watchdog not enabled");

    // level 2 ignores both enable bits: every expiry is a reset
    property p_level2_reset_mode;
        (fuse_prog && timeout) |=> wd_reset_pulse && !$rose(wd_irq_flag);
    endproperty
    a_level2_reset_mode: assert property (p_level2_reset_mode)
        else $error("level 2 time-out gave no reset");

    property p_locked_timeout;
        (wr_ctrl && fuse_prog && !key_open && !wd_reset_pulse)
            |=> $stable(timeout_select);
    endproperty
    a_locked_timeout: assert property (p_locked_timeout)
        else $error("timeout changed without key");

    property p_flag_cleared;
        (irq_ack && wd_irq_flag && !to_irq) |=> !wd_irq_flag;
    endproperty
    a_flag_cleared: assert property (p_flag_cleared)
        else $error("vector did not clear flag");

    property p_irq_mode_no_reset;
        (timeout && irq_mode && !wde_eff)
            |=> wd_irq_flag && !wd_reset_pulse ##1 !wd_reset_pulse;
    endproperty
    a_irq_mode_no_reset: assert property (p_irq_mode_no_reset)
        else $error("interrupt mode time-out misbehaved");

    property p_combined_ack;
        (irq_ack && wd_irq_flag && wde_eff && !wr_ctrl
            && !wd_reset_pulse) |=> !wd_irq_enable;
    endproperty
    a_combined_ack: assert property (p_combined_ack)
        else $error("vector left irq enable set");

    property p_second_timeout;
        (timeout && irq_mode && wde_eff && wd_irq_flag && !irq_ack)
            |=> wd_reset_pulse ##1 wd_reset_cause_flag;
    endproperty
    a_second_timeout: assert property (p_second_timeout)
        else $error("second time-out gave no reset");

    property p_cause_forces_wde;
        wd_reset_cause_flag |-> ctrl_read[BIT_WDE];
    endproperty
    a_cause_forces_wde: assert property (p_cause_forces_wde)
        else $error("reset enable low while cause set");

    property p_pulse_one_cycle;
        $rose(wd_reset_pulse) |=> !wd_reset_pulse [*2];
    endproperty
    a_pulse_one_cycle: assert property (p_pulse_one_cycle)
        else $error("reset pulse wider than one clock");

    property p_request_level;
        (to_irq && wd_irq_enable && !irq_ack && !wr_ctrl
            && !wd_reset_pulse) |=> wd_irq_request;
    endproperty
    a_request_level: assert property (p_request_level)
        else $error("interrupt not requested");
endmodule : watchdog_timer_config

// File: wd_core_model.sv
// core side: free-running watchdog oscillator and vector execution
module wd_core_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // interrupt handshake
    input  wire logic wd_irq_request,
    input  wire logic service_en,
    output logic      irq_ack,
    // watchdog oscillator pin
    output logic      osc_128k
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] lat;

    // 7812 ns period, never stopped: the oscillator runs free
    initial begin
        osc_128k = 1'b0;
        forever #3906 osc_128k = ~osc_128k;
    end

    // vector fetched two cycles after the request is seen, one-cycle ack
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            lat <= 2'h0;
            irq_ack <= 1'b0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            lat <= 2'h0;
        end else if (wd_irq_request && service_en) begin
            lat <= lat + 2'h1;
            irq_ack <= (lat == 2'h2);
        end else begin
            lat <= 2'h0;
        end
    end
endmodule : wd_core_model

// File: watchdog_timer_config_tb.sv
// bench for the watchdog control block
module watchdog_timer_config_tb
    import wd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic reset, fuse, irq_ack, service, osc, irq_req, rst_pulse;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int rst_cnt = 0;

    // short base count keeps every time-out a few hundred clocks long
    watchdog_timer_config #(.BASE(4)) dut (
        .clk(clk), .reset(reset), .safety_level_fuse(fuse),
        .osc_128k(osc), .irq_ack(irq_ack), .wd_irq_request(irq_req),
        .wd_reset_pulse(rst_pulse), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    wd_core_model core (
        .clk(clk), .reset(reset), .wd_irq_request(irq_req),
        .service_en(service), .irq_ack(irq_ack), .osc_128k(osc));

    // 10 MHz clock
    always #50 clk = ~clk;

    // cycle count for the hang guard and reset pulse tally
    always @(posedge clk) begin
        cycles++;
        if (rst_pulse === 1'b1) rst_cnt++;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", what, e, g);
            errors++;
        end
    endtask : chk

    // write: address and data offered together, released when taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        @(posedge clk);
        awaddr <= {idx[5:0], 2'b00};
        wdata <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge clk);
        while (awready !== 1'b1 || wready !== 1'b1) @(negedge clk);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge clk);
        while (bvalid !== 1'b1) @(negedge clk);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge clk);
        while (arready !== 1'b1) @(negedge clk);
        @(posedge clk);
        arvalid <= 1'b0;
        @(negedge clk);
        while (rvalid !== 1'b1) @(negedge clk);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd

    task automatic rdc(input logic [7:0] idx, input logic [7:0] e,
                       input string what);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(what, {24'h0, e}, d);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : rdc

    // waits for the reset pulse or the interrupt request, bounded
    task automatic wait_ev(input bit want_rst, input int lim, output int n);
        n = 0;
        @(negedge clk);
        while ((want_rst ? rst_pulse : irq_req) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_ev

    task automatic do_reset(input logic f);
        @(posedge clk);
        fuse <= f;
        service <= 1'b0;
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : do_reset

    task automatic t_level1();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        rdc(IDX_CTRL, 8'h00, "ctrl reset");
        rd(8'h00, d, r);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        wr(IDX_CTRL, 8'h08);
        rdc(IDX_CTRL, 8'h08, "ctrl armed");
        wr(IDX_CTRL, 8'h00);
        rdc(IDX_CTRL, 8'h08, "ctrl no key");
        wr(IDX_KEY, KEY_VALUE);
        repeat (6) @(posedge clk);
        wr(IDX_CTRL, 8'h00);
        rdc(IDX_CTRL, 8'h08, "ctrl late key");
        wr(IDX_KEY, KEY_VALUE);
        wr(IDX_CTRL, 8'h00);
        rdc(IDX_CTRL, 8'h00, "ctrl off");
        wait_ev(1'b1, 500, n);
        chk("stopped", 32'd500, n);
        chk("stopped irq", 32'h0, {31'h0, irq_req});
        wr(IDX_CTRL, 8'h31);
        rdc(IDX_CTRL, 8'h21, "ctrl tsel nine");
        wr(IDX_CTRL, 8'h22);
        rdc(IDX_CTRL, 8'h21, "ctrl reserved code");
        $display("test level1 done");
    endtask : t_level1

    task automatic t_int_mode();
        int n;
        int r0;
        r0 = rst_cnt;
        wr(IDX_CTRL, 8'h41);
        wr(IDX_KICK, 8'h01);
        wait_ev(1'b0, 900, n);
        cmp_count++;
        if (n < 530 || n > 640) begin
            $display("BAD period exp 530..640 got %0d", n);
            errors++;
        end
        rdc(IDX_CTRL, 8'hc1, "flag set");
        chk("irq req", 32'h1, {31'h0, irq_req});
        wr(IDX_CTRL, 8'hc1);
        rdc(IDX_CTRL, 8'h41, "flag w1c");
        chk("irq req off", 32'h0, {31'h0, irq_req});
        service <= 1'b1;
        wait_ev(1'b0, 900, n);
        chk("second irq", 32'h1, {31'h0, n < 900});
        repeat (6) @(posedge clk);
        rdc(IDX_CTRL, 8'h41, "vector clear");
        chk("no reset", r0, rst_cnt);
        service <= 1'b0;
        $display("test interrupt mode done");
    endtask : t_int_mode

    task automatic t_combined();
        int n;
        do_reset(1'b0);
        service <= 1'b1;
        wr(IDX_CTRL, 8'h48);
        wait_ev(1'b0, 500, n);
        chk("first irq", 32'h1, {31'h0, n < 500});
        repeat (6) @(posedge clk);
        rdc(IDX_CTRL, 8'h08, "after vector");
        wait_ev(1'b1, 500, n);
        chk("reset mode", 32'h1, {31'h0, n < 500});
        @(negedge clk);
        chk("pulse width", 32'h0, {31'h0, rst_pulse});
        rdc(IDX_CAUSE, 8'h08, "cause set");
        wr(IDX_KEY, KEY_VALUE);
        wr(IDX_CTRL, 8'h00);
        rdc(IDX_CTRL, 8'h08, "forced enable");
        wr(IDX_CAUSE, 8'h00);
        rdc(IDX_CAUSE, 8'h00, "cause clear");
        wr(IDX_KEY, KEY_VALUE);
        wr(IDX_CTRL, 8'h00);
        rdc(IDX_CTRL, 8'h00, "off after clear");
        service <= 1'b0;
        wr(IDX_CTRL, 8'h48);
        wait_ev(1'b0, 500, n);
        chk("pending irq", 32'h1, {31'h0, n < 500});
        wait_ev(1'b1, 500, n);
        chk("second timeout", 32'h1, {31'h0, n < 500});
        $display("test combined mode done");
    endtask : t_combined

    task automatic t_fuse2();
        int n;
        int r0;
        do_reset(1'b1);
        rdc(IDX_CTRL, 8'h08, "level2 on");
        wr(IDX_CTRL, 8'h01);
        rdc(IDX_CTRL, 8'h08, "level2 no key");
        wr(IDX_KEY, KEY_VALUE);
        wr(IDX_CTRL, 8'h01);
        rdc(IDX_CTRL, 8'h09, "level2 tsel");
        // kicks spaced well inside one period must hold off the reset
        r0 = rst_cnt;
        repeat (4) begin
            repeat (200) @(posedge clk);
            wr(IDX_KICK, 8'h01);
        end
        chk("kick holds off", r0, rst_cnt);
        wait_ev(1'b1, 800, n);
        chk("level2 reset", 32'h1, {31'h0, n < 800});
        $display("test level2 done");
    endtask : t_fuse2

    // main sequence
    initial begin
        reset = 1'b1;
        fuse = 1'b0;
        service = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        // the scenarios race the hang guard; either way one verdict
        fork
            begin
                do_reset(1'b0);
                t_level1();
                t_int_mode();
                t_combined();
                t_fuse2();
            end
            begin
                wait (cycles >= LIMIT);
                errors++;
                $display("BAD timeout exp done got hang");
            end
        join_any
        test_done();
    end
endmodule : watchdog_timer_config_tb
